// ---- hdl/asrp_counter.sv ----
`default_nettype none
module asrp_counter #(
   parameter int CNT_W = 20
) (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic load_in,
   input wire logic [CNT_W-1:0] value_in,
   output logic done_out
);
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (load_in) begin
         cnt_nxt = value_in;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign done_out = (cnt_r == '0) && !load_in;
endmodule
`default_nettype wire

// ---- hdl/asrp_host.sv ----
`default_nettype none
// How it works
// R1 - Memory holds 131072 bytes, 17-bit address
// R2 - Selected only when both selects active
// R3 - Device drives data only on read gate
// R4 - Device floats data otherwise
// R5 - Write happens while selected, strobe low
// R6 - Gate high keeps device pins floating
// R7 - Strobe overlap held at least 50 ns
// R8 - Select overlap held at least 60 ns
// R9 - Host releases bus before enabling outputs
// R10 - Wait 70 ns before sampling read data
// R11 - Deselect before power drop, 5 ms after
// R12 - Device needs no clock or refresh
// R13 - Data pins shared both directions
// R14 - Address stable during each access
module asrp_host #(
   parameter int TRAIL_CYCLES = asrp_pkg::TRAIL_CYC
) (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic req_valid_in,
   input wire asrp_pkg::asrp_req_s req_in,
   output logic req_ready_out,
   output logic rd_valid_out,
   output logic [asrp_pkg::DATA_W-1:0] rd_data_out,
   input wire logic power_down_in,
   input wire logic power_restored_in,
   output logic retention_busy_out,
   output asrp_pkg::asrp_pins_s pins_out,
   input wire logic [asrp_pkg::DATA_W-1:0] shared_data_pins_in,
   output logic [asrp_pkg::DATA_W-1:0] shared_data_pins_out,
   output logic shared_data_pins_oe_out
);
   asrp_pkg::asrp_state_e state_r, state_nxt;
   asrp_pkg::asrp_pins_s pins_r, pins_nxt;
   logic [asrp_pkg::DATA_W-1:0] wdata_r, wdata_nxt;
   logic oe_r, oe_nxt;
   logic [asrp_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic load;
   logic [asrp_pkg::CNT_W-1:0] load_val;
   logic done;
   logic take;
   logic start_hold;
   logic access_end;
   logic read_end;

   asrp_counter #(.CNT_W(asrp_pkg::CNT_W)) u_cnt (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .load_in(load),
      .value_in(load_val),
      .done_out(done)
   );

   // Request taken at this edge
   assign take = req_valid_in && req_ready_out;
   assign start_hold = (state_r == asrp_pkg::ASRP_IDLE) && power_down_in;
   assign access_end = done && ((state_r == asrp_pkg::ASRP_READ) || (state_r == asrp_pkg::ASRP_WRITE));
   assign read_end = done && (state_r == asrp_pkg::ASRP_READ);

   // Sequencer and access timer
   always_comb begin
      state_nxt = state_r;
      load = 1'b0;
      load_val = asrp_pkg::CNT_ZERO;
      unique case (state_r)
         asrp_pkg::ASRP_IDLE: begin
            if (start_hold) begin
               load = 1'b1;
               load_val = asrp_pkg::CNT_W'(TRAIL_CYCLES); // R11
               state_nxt = asrp_pkg::ASRP_HOLD;
            end else if (take) begin
               load = 1'b1;
               if (req_in.write) begin
                  load_val = asrp_pkg::CNT_W'(asrp_pkg::WRITE_CYC - 1); // R7 R8
                  state_nxt = asrp_pkg::ASRP_WRITE;
               end else begin
                  load_val = asrp_pkg::CNT_W'(asrp_pkg::READ_CYC - 1); // R10
                  state_nxt = asrp_pkg::ASRP_READ;
               end
            end
         end
         asrp_pkg::ASRP_READ, asrp_pkg::ASRP_WRITE: begin
            if (access_end) begin
               state_nxt = asrp_pkg::ASRP_RECOV;
            end
         end
         asrp_pkg::ASRP_RECOV: begin
            state_nxt = asrp_pkg::ASRP_IDLE;
         end
         asrp_pkg::ASRP_HOLD: begin
            // Trail time runs only once the supply is back
            if (power_down_in || !power_restored_in) begin
               load = 1'b1;
               load_val = asrp_pkg::CNT_W'(TRAIL_CYCLES); // R11
            end else if (done) begin
               state_nxt = asrp_pkg::ASRP_IDLE; // R11
            end
         end
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         state_r <= asrp_pkg::ASRP_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Pin sequencing, all pins change on one edge
   always_comb begin
      pins_nxt = pins_r;
      unique case (state_r)
         asrp_pkg::ASRP_IDLE: begin
            if (start_hold) begin
               pins_nxt.select_low_active_n = 1'b1; // R11
               pins_nxt.select_high_active = 1'b0; // R11
               pins_nxt.output_gate_n = 1'b1;
               pins_nxt.write_strobe_n = 1'b1;
            end else if (take) begin
               pins_nxt.word_address_lines = req_in.addr; // R1
               pins_nxt.select_low_active_n = 1'b0; // R2
               pins_nxt.select_high_active = 1'b1; // R2
               pins_nxt.output_gate_n = req_in.write; // R3 R6
               pins_nxt.write_strobe_n = !req_in.write; // R5
            end
         end
         asrp_pkg::ASRP_READ, asrp_pkg::ASRP_WRITE: begin
            if (access_end) begin
               pins_nxt.output_gate_n = 1'b1; // R4
               pins_nxt.write_strobe_n = 1'b1; // R7
               pins_nxt.select_low_active_n = 1'b1; // R8
               pins_nxt.select_high_active = 1'b0; // R8
            end
         end
         asrp_pkg::ASRP_RECOV, asrp_pkg::ASRP_HOLD: begin
            pins_nxt = pins_r;
         end
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         pins_r.select_low_active_n <= 1'b1;
         pins_r.select_high_active <= 1'b0;
         pins_r.output_gate_n <= 1'b1;
         pins_r.write_strobe_n <= 1'b1;
         pins_r.word_address_lines <= '0;
      end else begin
         pins_r <= pins_nxt; // R14
      end
   end

   // Host drive stays on one cycle past the strobe rise
   always_comb begin
      wdata_nxt = wdata_r;
      oe_nxt = oe_r;
      unique case (state_r)
         asrp_pkg::ASRP_IDLE: begin
            if (start_hold) begin
               oe_nxt = 1'b0;
            end else if (take) begin
               oe_nxt = req_in.write; // R9 R13
               if (req_in.write) begin
                  wdata_nxt = req_in.wdata;
               end
            end
         end
         asrp_pkg::ASRP_RECOV: begin
            oe_nxt = 1'b0; // R9
         end
         asrp_pkg::ASRP_READ, asrp_pkg::ASRP_WRITE, asrp_pkg::ASRP_HOLD: begin
            oe_nxt = oe_r;
         end
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         wdata_r <= '0;
         oe_r <= 1'b0;
      end else begin
         wdata_r <= wdata_nxt;
         oe_r <= oe_nxt;
      end
   end

   // Read data taken at the end of the access window
   always_comb begin
      rdata_nxt = rdata_r;
      rvalid_nxt = 1'b0;
      if (read_end) begin
         rdata_nxt = shared_data_pins_in; // R10
         rvalid_nxt = 1'b1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         rdata_r <= '0;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   assign req_ready_out = (state_r == asrp_pkg::ASRP_IDLE) && !power_down_in;
   assign rd_valid_out = rvalid_r;
   assign rd_data_out = rdata_r;
   assign retention_busy_out = (state_r == asrp_pkg::ASRP_HOLD);
   assign pins_out = pins_r;
   assign shared_data_pins_out = wdata_r;
   assign shared_data_pins_oe_out = oe_r; // R9
endmodule
`default_nettype wire

// ---- shared/asrp_pkg.sv ----
`default_nettype none
package asrp_pkg;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_NS = 10;
   // Timing figures in their own units
   localparam int WRITE_OVERLAP_WIDTH_NS = 50;
   localparam int SELECT_WRITE_OVERLAP_NS = 60;
   localparam int READ_ACCESS_NS = 70;
   localparam int RETENTION_SELECT_LEAD_NS = 0;
   localparam int RETENTION_SELECT_TRAIL_MS = 5;
   // Least times round up, read adds one cycle
   localparam int WRITE_CYC = (SELECT_WRITE_OVERLAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int TRAIL_CYC = RETENTION_SELECT_TRAIL_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CNT_W = 20;
   localparam logic [CNT_W-1:0] CNT_ZERO = 20'h0_0000;

   typedef enum logic [4:0] {
      ASRP_IDLE = 5'b00001,
      ASRP_READ = 5'b00010,
      ASRP_WRITE = 5'b00100,
      ASRP_RECOV = 5'b01000,
      ASRP_HOLD = 5'b10000
   } asrp_state_e;

   typedef struct packed {
      logic select_low_active_n;
      logic select_high_active;
      logic output_gate_n;
      logic write_strobe_n;
      logic [ADDR_W-1:0] word_address_lines;
   } asrp_pins_s;

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } asrp_req_s;
endpackage
`default_nettype wire

// ---- testbench/asrp_host_sva.sv ----
`default_nettype none
module asrp_host_sva #(parameter int TRAIL_CYCLES = asrp_pkg::TRAIL_CYC) (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic power_down_in,
   input wire logic power_restored_in,
   input wire logic rd_valid_out,
   input wire logic retention_busy_out,
   input wire asrp_pkg::asrp_pins_s pins_out,
   input wire logic shared_data_pins_oe_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   wire logic s = !pins_out.select_low_active_n && pins_out.select_high_active;
   wire logic w = !pins_out.write_strobe_n;
   wire logic r = !pins_out.output_gate_n;
   int trail_cnt;
   // Cycles in hold since the supply came back
   always_ff @(posedge mclk_in) begin
      if (!nrst_in || !retention_busy_out || power_down_in || !power_restored_in) begin
         trail_cnt <= 0;
      end else begin
         trail_cnt <= trail_cnt + 1;
      end
   end
   property p_wp; $rose(w) |-> (w && s) [*6]; endproperty
   a_wp: assert property (p_wp) else $error("strobe overlap");
   property p_cw; $rose(s) && w |-> (w && s) [*6]; endproperty
   a_cw: assert property (p_cw) else $error("select overlap");
   property p_bus; r |-> !shared_data_pins_oe_out; endproperty
   a_bus: assert property (p_bus) else $error("bus fight");
   property p_acc; $rose(r) |-> !rd_valid_out [*8] ##1 rd_valid_out; endproperty
   a_acc: assert property (p_acc) else $error("sample time");
   property p_adr; (w || r) && $past(w || r) |-> $stable(pins_out.word_address_lines); endproperty
   a_adr: assert property (p_adr) else $error("address moved");
   property p_wg; w |-> s && !r && shared_data_pins_oe_out; endproperty
   a_wg: assert property (p_wg) else $error("write gating");
   property p_ret; retention_busy_out |-> !s; endproperty
   a_ret: assert property (p_ret) else $error("retention select");
   property p_trail; $fell(retention_busy_out) |-> trail_cnt >= TRAIL_CYCLES; endproperty
   a_trail: assert property (p_trail) else $error("retention trail too short");
endmodule
bind asrp_host asrp_host_sva #(.TRAIL_CYCLES(TRAIL_CYCLES)) u_sva (
   .mclk_in(mclk_in),
   .nrst_in(nrst_in),
   .power_down_in(power_down_in),
   .power_restored_in(power_restored_in),
   .rd_valid_out(rd_valid_out),
   .retention_busy_out(retention_busy_out),
   .pins_out(pins_out),
   .shared_data_pins_oe_out(shared_data_pins_oe_out)
);
`default_nettype wire

// ---- testbench/asrp_sram_model.sv ----
`default_nettype none
module asrp_sram_model (
   input wire asrp_pkg::asrp_pins_s pins_in,
   input wire logic [7:0] bus_in,
   output logic [7:0] drive_out,
   output logic oe_out
);
   timeunit 1ns / 1ps;
   logic [7:0] mem [0:131071];
   wire logic s = !pins_in.select_low_active_n && pins_in.select_high_active;
   assign oe_out = s && !pins_in.output_gate_n && pins_in.write_strobe_n;
   assign #70 drive_out = mem[pins_in.word_address_lines];
   always @* if (s && !pins_in.write_strobe_n) mem[pins_in.word_address_lines] = bus_in;
endmodule
`default_nettype wire

// ---- testbench/test_async_static_ram_port.sv ----
`default_nettype none
module test_async_static_ram_port;
   timeunit 1ns / 1ps;
   logic mclk_in = 1'h0, nrst_in = 1'h0, req_valid_in = 1'h0, power_down_in = 1'h0, power_restored_in = 1'h0;
   logic req_ready_out, rd_valid_out, retention_busy_out, shared_data_pins_oe_out, m_oe;
   logic [7:0] rd_data_out, shared_data_pins_in, shared_data_pins_out, m_d, d [8], exp_q [$];
   logic [16:0] a [8];
   asrp_pkg::asrp_req_s req_in = '0;
   asrp_pkg::asrp_pins_s pins_out;
   int err_total = 0, cmp_count = 0, n;
   always #5 mclk_in = ~mclk_in;
   assign shared_data_pins_in = shared_data_pins_oe_out ? shared_data_pins_out : m_oe ? m_d : {8{mclk_in}};
   asrp_host #(.TRAIL_CYCLES(20)) dut (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .req_valid_in(req_valid_in),
      .req_in(req_in),
      .req_ready_out(req_ready_out),
      .rd_valid_out(rd_valid_out),
      .rd_data_out(rd_data_out),
      .power_down_in(power_down_in),
      .power_restored_in(power_restored_in),
      .retention_busy_out(retention_busy_out),
      .pins_out(pins_out),
      .shared_data_pins_in(shared_data_pins_in),
      .shared_data_pins_out(shared_data_pins_out),
      .shared_data_pins_oe_out(shared_data_pins_oe_out)
   );
   asrp_sram_model mem (.pins_in(pins_out), .bus_in(shared_data_pins_in), .drive_out(m_d), .oe_out(m_oe));
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] want);
      cmp_count++;
      err_total += int'(seen !== want);
      if (seen !== want) $display("unexpected %s expected %h seen %h", nm, want, seen);
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic await(input bit hold, input logic want);
      for (n = 1; n < 99; n++) begin
         @(posedge mclk_in);
         if ((hold ? retention_busy_out : req_ready_out) === want) return;
      end
      err_total++;
      give_verdict();
   endtask
   task automatic send(input logic wr, input int i);
      req_valid_in <= 1'h1;
      req_in <= '{wr, a[i], d[i]};
      if (!wr) exp_q.push_back(d[i]);
      await(1'h0, 1'h1);
   endtask
   always @(posedge mclk_in) if (rd_valid_out === 1'h1)
      check("read", rd_data_out, exp_q.size() ? exp_q.pop_front() : 8'hxx);
   initial begin
      void'($urandom(32'h771e_5ea2));
      foreach (a[i]) begin
         {a[i], d[i]} = 25'($urandom);
         a[i][2:0] = 3'(i); // Distinct addresses
      end
      a[7] = '1;
      repeat (12) @(posedge mclk_in);
      nrst_in <= 1'h1;
      for (int i = 0; i < 16; i++) send(i < 8, i % 8);
      req_valid_in <= 1'h0;
      await(1'h0, 1'h1);
      power_down_in <= 1'h1;
      await(1'h1, 1'h1);
      check("ready", 8'(req_ready_out), 8'h00);
      power_down_in <= 1'h0;
      power_restored_in <= 1'h1;
      await(1'h1, 1'h0);
      check("hold", 8'(n >= 20), 8'h01);
      send(1'h0, 7);
      req_valid_in <= 1'h0;
      await(1'h0, 1'h1);
      @(posedge mclk_in);
      check("left", 8'(exp_q.size()), 8'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
